/* File: imc_control.v */
// AHB-Lite control register block of the integrity monitor.
//
// Overview of operation
// - Writing one to a bit of bits 15:12 starts monitoring of that region; zero leaves it alone.
// - Writing one to a bit of bits 11:8 stops monitoring of that region; zero does nothing.
// - Writing one to a bit of bits 7:4 requests a new digest of that region; zero does nothing.
// - A digest request is honoured only while the region is not monitored, and software disables first.
// - After reset every region is monitored without any software write.
`timescale 1ns/1ps
`default_nettype none
`include "imc_regs.vh"
module imc_control
#(
    parameter REGIONS = 4
)
(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [REGIONS-1:0] recompute_done,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg [REGIONS-1:0] region_watch,
    output reg [REGIONS-1:0] digest_recompute
);
    ////////////////////////////////////////////////////////////////////////////
    reg wr_pend;
    reg [`IMC_ADDR_MSB:0] wr_addr;
    wire [REGIONS-1:0] watching;
    wire [REGIONS-1:0] pending;
    wire cmd_valid;
    wire take;
    wire [REGIONS-1:0] watch_on;
    wire [REGIONS-1:0] watch_off;
    wire [REGIONS-1:0] recompute;
    reg [31:0] next_hrdata;

    ////////////////////////////////////////////////////////////////////////////
    // Only the low address bits are decoded, so the block aliases across its window.
    function addr_hit;
        input [`IMC_ADDR_MSB:0] addr;
        input [`IMC_ADDR_MSB:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    // Each command field holds one bit per region, region zero at the field's low end.
    function [REGIONS-1:0] region_field;
        input [31:0] word;
        input integer lsb;
        begin
            region_field = word[lsb +: REGIONS];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    assign take = hsel && hready && htrans[1];
    assign cmd_valid = wr_pend && addr_hit(wr_addr, `IMC_CMD_OFFSET);
    assign watch_on = region_field(hwdata, `IMC_WATCH_ON_LSB);
    assign watch_off = region_field(hwdata, `IMC_WATCH_OFF_LSB);
    assign recompute = region_field(hwdata, `IMC_RECOMPUTE_LSB);

    ////////////////////////////////////////////////////////////////////////////
    // Writes are applied in the data phase, when hwdata is valid.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= {(`IMC_ADDR_MSB+1){1'b0}};
        end
        else
        begin
            wr_pend <= take && hwrite;
            if (take)
                wr_addr <= haddr[`IMC_ADDR_MSB:0];
        end
    end

    // Reads return state; the command word itself always reads as zero.
    always @*
    begin
        next_hrdata = 32'h0000_0000;
        if (take && !hwrite)
        begin
            if (addr_hit(haddr[`IMC_ADDR_MSB:0], `IMC_STATE_OFFSET))
                next_hrdata[REGIONS-1:0] = watching;
            else if (addr_hit(haddr[`IMC_ADDR_MSB:0], `IMC_PEND_OFFSET))
                next_hrdata[REGIONS-1:0] = pending;
        end
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            region_watch <= `IMC_WATCH_RESET;
            digest_recompute <= {REGIONS{1'b0}};
        end
        else
        begin
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            region_watch <= watching;
            digest_recompute <= pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    genvar i;
    generate
        for (i = 0; i < REGIONS; i = i + 1)
        begin : g_region
            imc_region_slot u_slot
            (
                .hclk(hclk),
                .hresetn(hresetn),
                .cmd_valid(cmd_valid),
                .watch_on(watch_on[i]),
                .watch_off(watch_off[i]),
                .recompute(recompute[i]),
                .recompute_done(recompute_done[i]),
                .watching(watching[i]),
                .recompute_pending(pending[i])
            );
        end
    endgenerate
endmodule // imc_control
`default_nettype wire

/* File: imc_regs.vh */
// Register map, field positions and reset values of the integrity monitor control block.
`ifndef IMC_REGS_VH
`define IMC_REGS_VH
`define IMC_CMD_OFFSET 12'h004
`define IMC_STATE_OFFSET 12'h008
`define IMC_PEND_OFFSET 12'h00C
`define IMC_ADDR_MSB 11
`define IMC_WATCH_ON_LSB 12
`define IMC_WATCH_OFF_LSB 8
`define IMC_RECOMPUTE_LSB 4
`define IMC_WATCH_RESET 4'hF
`endif

/* File: imc_region_slot.v */
// Monitoring state and pending recompute request of one memory region.
`timescale 1ns/1ps
`default_nettype none
module imc_region_slot
(
    input wire hclk,
    input wire hresetn,
    input wire cmd_valid,
    input wire watch_on,
    input wire watch_off,
    input wire recompute,
    input wire recompute_done,
    output reg watching,
    output reg recompute_pending
);
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            watching <= 1'b1;
            recompute_pending <= 1'b0;
        end
        else
        begin
            // Off wins when software sets both bits in one write.
            if (cmd_valid && watch_off)
                watching <= 1'b0;
            else if (cmd_valid && watch_on)
                watching <= 1'b1;
            // A new request in the same cycle as a completion keeps the request.
            if (cmd_valid && recompute && !watching)
                recompute_pending <= 1'b1;
            else if (recompute_done)
                recompute_pending <= 1'b0;
        end
    end
endmodule // imc_region_slot
`default_nettype wire

/* File: imc_control_asserts.sv */
// Port assertions of the integrity monitor control block.
`timescale 1ns/1ps
`default_nettype none
module imc_control_asserts
(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire [3:0] region_watch,
    input wire [3:0] digest_recompute
);
default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);
logic wr_d;
logic rd_d;
wire cmd = hsel && hready && htrans[1] && haddr[11:0] == 12'h004;
always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) {wr_d, rd_d} <= 2'b00;
    else {wr_d, rd_d} <= {cmd && hwrite, cmd && !hwrite};
// The data-phase word is applied at the edge ending it and shows on the outputs one edge later.
sequence cmd_write;
    wr_d;
endsequence
AST_ON: assert property (cmd_write |-> ##2 (~region_watch & $past(hwdata[15:12], 2) & ~$past(hwdata[11:8], 2)) == 4'h0)
    else $error("region not watched after on command");
AST_OFF: assert property (cmd_write |-> ##2 (region_watch & $past(hwdata[11:8], 2)) == 4'h0)
    else $error("region still watched after off command");
AST_NEW_DIGEST: assert property ((digest_recompute & ~$past(digest_recompute)
    & ~({4{$past(wr_d, 2)}} & $past(hwdata[7:4], 2))) == 4'h0) else $error("digest request without command");
AST_RESET: assert property ($rose(hresetn) |-> region_watch == 4'hF && digest_recompute == 4'h0)
    else $error("wrong state after reset");
AST_READ: assert property (rd_d |-> hrdata == 32'h0000_0000)
    else $error("command register read not zero");
AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus response not ready okay");
endmodule // imc_control_asserts
bind imc_control imc_control_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .region_watch, .digest_recompute);
`default_nettype wire

/* File: imc_control_test.sv */
// Self-checking bench of the integrity monitor control block.
`timescale 1ns/1ps
`default_nettype none
module imc_control_test;
logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
logic [1:0] htrans = 0;
logic [31:0] haddr = 0, hwdata = 0, rd, d;
logic [3:0] done = 0, w = 4'hF, p = 0;
wire hready, hresp;
wire [31:0] hrdata;
wire [3:0] watch, pend;
integer failures = 0, n_checks = 0, seed = 32'h9fd3_9cc7, k, i;
initial forever #10 hclk = ~hclk;
imc_control u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready,
    .recompute_done(done), .hrdata, .hreadyout(hready), .hresp, .region_watch(watch), .digest_recompute(pend));
task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask
task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
        failures++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task wait_ready;
    for (k = 0; k < 50; k++)
    begin
        @(posedge hclk);
        if (hready === 1'b1) return;
    end
    failures++;
    end_of_test();
endtask
task bus(input logic wr, input logic [31:0] a, input logic [31:0] dat);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, wr, a};
    wait_ready();
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, dat};
    wait_ready();
    rd = hrdata;
endtask
// Off wins over on; a digest request counts only for a region not watched before the write.
function logic [3:0] nw(input logic [3:0] s, input logic [31:0] x);
    return (s | x[15:12]) & ~x[11:8];
endfunction
task wr_chk(input logic [31:0] x);
    bus(1, 32'h4, x);
    p = p | (x[7:4] & ~w);
    w = nw(w, x);
    repeat (2) @(posedge hclk);
    check(watch, w);
    check(pend, p);
    bus(0, 32'h4, 0);
    check(rd, 0);
    check(hresp, 0);
    bus(0, 32'h8, 0);
    check(rd, w);
    bus(0, 32'hC, 0);
    check(rd, p);
endtask
initial
begin
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    check(watch, 4'hF);
    check(pend, 4'h0);
    $display("test reset done");
    wr_chk(32'h0000_00F0);
    wr_chk(32'h0000_0F00);
    wr_chk(32'h0000_00F0);
    wr_chk(32'h0000_F000);
    $display("test corners done");
    for (i = 0; i < 40; i++)
    begin
        d = $random(seed);
        d[7:4] = d[7:4] & ~(d[15:12] | d[11:8]);
        wr_chk(d);
        done <= $random(seed);
        @(posedge hclk);
        p = p & ~done;
        done <= 0;
    end
    $display("test random done");
    end_of_test();
end
endmodule // imc_control_test
`default_nettype wire
